// file: common/audio_irq_pkg.sv
// package: register layout and event types for the audio interrupt block
package audio_irq_pkg;
  localparam int reg_width = 16;
  localparam logic [15:0] status_ctrl_reset = 16'h0000;
  // enable bits
  localparam int rx_irq_en_bit = 0;
  localparam int rx_err_irq_en_bit = 1;
  localparam int tx_irq_en_bit = 2;
  localparam int tx_err_irq_en_bit = 3;
  // pending bits
  localparam int rx_pending_bit = 4;
  localparam int rx_err_pending_bit = 5;
  localparam int tx_pending_bit = 6;
  localparam int tx_err_pending_bit = 7;
  // clear bits
  localparam int rx_clear_bit = 8;
  localparam int rx_err_clear_bit = 9;
  localparam int tx_clear_bit = 10;
  localparam int tx_err_clear_bit = 11;
  localparam int enable_lsb = 0;
  localparam int pending_lsb = 4;
  localparam int clear_lsb = 8;

  // one bit per source: {tx_err, tx, rx_err, rx}
  typedef struct packed {
    logic tx_err;
    logic tx;
    logic rx_err;
    logic rx;
  } src_type;

  typedef struct packed {
    src_type enable;
    src_type pending;
    logic irq;
    logic overrun;
  } state_type;
endpackage

// file: dv/audio_irq_properties.sv
// checker for the audio interrupt block
`timescale 1ns/10ps
`default_nettype none
module audio_irq_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_word_done,
  input wire logic rx_fifo_full,
  input wire logic tx_err_event,
  input wire logic rx_overrun_flag,
  input wire logic irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_irq_combine: assert property (irq_request == |(reg_rdata[7:4] & reg_rdata[3:0]))
    else $error("irq request wrong");
  a_overrun_sets: assert property (rx_word_done && rx_fifo_full |=> rx_overrun_flag && reg_rdata[5])
    else $error("overrun not flagged");
  sequence s_tx_err_clear_write;
    reg_wr && reg_wdata[11] && !tx_err_event;
  endsequence
  a_tx_err_clear: assert property (s_tx_err_clear_write |=> !reg_rdata[7])
    else $error("tx error pending not cleared");
  a_tx_err_set: assert property (tx_err_event |=> reg_rdata[7])
    else $error("tx error pending not set");
  a_reads_zero: assert property (reg_rdata[15:8] == 8'h00)
    else $error("upper bits not zero");
  a_enable_load: assert property (reg_wr |=> reg_rdata[3:0] == $past(reg_wdata[3:0]))
    else $error("enable not loaded");
  a_pend_hold: assert property (reg_rdata[7] && !(reg_wr && reg_wdata[11]) |=> reg_rdata[7])
    else $error("pending lost");
endmodule
bind audio_irq_status_control audio_irq_properties u_audio_irq_properties(.*);
`default_nettype wire

// file: dv/irq_unit_model.sv
// interrupt control unit model, latches a request
`timescale 1ns/10ps
`default_nettype none
module irq_unit_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic irq_request,
  output logic irq_seen
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_seen <= 1'h0;
    end else if (irq_request) begin
      irq_seen <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// testbench for the audio interrupt block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import audio_irq_pkg::*;
  logic clk, sys_rst, reg_wr, rx_event, rx_word_done, rx_fifo_full, tx_event, tx_err_event;
  logic rx_overrun_flag, irq_request, irq_seen;
  logic [15:0] reg_wdata, reg_rdata;
  int failures = 0, checked = 0;
  // rows: events {tx_err,tx,overrun,rx}, write data, expected read
  logic [35:0] rows[3] = '{36'hf_0000_00f0, 36'h0_0f0f_000f, 36'h8_0008_0088};
  audio_irq_status_control u_audio_irq_status_control(.*);
  irq_unit_model u_irq_unit_model(.*);
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", name, e, s);
    end
  endtask
  task automatic chk_bit(input string name, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %b got %b", name, e, s);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    #10000 failures++;
    final_report();
  end
  initial begin
    {reg_wr, reg_wdata, rx_event, rx_word_done, tx_event, tx_err_event} = '0;
    rx_fifo_full = 1;
    sys_rst = 1;
    repeat (8) @(posedge clk);
    #1 sys_rst = 0;
    foreach (rows[i]) begin
      {tx_err_event, tx_event, rx_word_done, rx_event} = rows[i][35:32];
      @(posedge clk) #1 {tx_err_event, tx_event, rx_word_done, rx_event} = '0;
      reg_wr = 1;
      reg_wdata = rows[i][31:16];
      @(posedge clk) #1 reg_wr = 0;
      chk("reg_rdata", rows[i][15:0], reg_rdata);
    end
    chk_bit("irq_request", 1'b1, irq_request);
    @(posedge clk) #1 chk_bit("irq_seen", 1'b1, irq_seen);
    tx_err_event = 1;
    reg_wr = 1;
    reg_wdata = 16'h0808;
    @(posedge clk) #1 tx_err_event = 0;
    chk("reg_rdata", 16'h0088, reg_rdata);
    @(posedge clk) #1 reg_wr = 0;
    chk("reg_rdata", 16'h0008, reg_rdata);
    chk_bit("irq_request", 1'b0, irq_request);
    rx_fifo_full = 0;
    rx_word_done = 1;
    @(posedge clk) #1 chk_bit("rx_overrun_flag", 1'b0, rx_overrun_flag);
    rx_fifo_full = 1;
    @(posedge clk) #1 rx_word_done = 0;
    chk_bit("rx_overrun_flag", 1'b1, rx_overrun_flag);
    chk("reg_rdata", 16'h0028, reg_rdata);
    chk_bit("irq_request", 1'b0, irq_request);
    reg_wr = 1;
    reg_wdata = 16'h0002;
    @(posedge clk) #1 reg_wr = 0;
    chk_bit("irq_request", 1'b1, irq_request);
    chk_bit("rx_overrun_flag", 1'b0, rx_overrun_flag);
    rx_event = 1;
    reg_wr = 1;
    reg_wdata = 16'h0200;
    @(posedge clk) #1 {rx_event, reg_wr} = '0;
    chk("reg_rdata", 16'h0010, reg_rdata);
    chk_bit("irq_request", 1'b0, irq_request);
    reg_wr = 1;
    reg_wdata = 16'h0001;
    @(posedge clk) #1 reg_wr = 0;
    chk_bit("irq_request", 1'b1, irq_request);
    sys_rst = 1;
    #1 chk("reg_rdata", 16'h0000, reg_rdata);
    chk_bit("irq_request", 1'b0, irq_request);
    @(posedge clk) #1 sys_rst = 0;
    @(posedge clk) #1 reg_wr = 1;
    reg_wdata = 16'h0101;
    @(posedge clk) #1 reg_wr = 0;
    chk("reg_rdata", 16'h0001, reg_rdata);
    final_report();
  end
endmodule
`default_nettype wire

// file: src/audio_irq_status_control.sv
// audio interrupt status and control register with combined request
// Functional notes
// [R1] tx error event sets tx_err_pending; stays until a 1 is written to tx_err_clear.
// [R2] tx_err_pending reads 0 idle, 1 pending; writes never set it directly.
// [R3] rx_irq_en 0 blocks receive interrupts; 1 lets them through.
// [R4] rx_err_irq_en 1 raises receive error interrupt while rx_err_pending set; 0 blocks it.
// [R5] writing 1 to rx_clear clears rx_pending; 0 has no effect.
// [R6] writing 1 to rx_err_clear clears rx_err_pending; 0 leaves it.
// [R7] writing 1 to tx_clear clears tx_pending.
// [R8] writing 0 to tx_clear is ignored.
// [R9] writing 0 to tx_err_clear is ignored.
// [R10] reset clears the whole register to zero.
// [R11] overrun flagged when a full word arrives while receive fifo is full.
// [R12] irq_request high while any pending flag has its enable set.
// [R13] clear and reserved bits read 0; clears act in the write cycle.
`timescale 1ns/10ps
`default_nettype none
module audio_irq_status_control
  import audio_irq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic rx_event,
  input wire logic rx_word_done,
  input wire logic rx_fifo_full,
  input wire logic tx_event,
  input wire logic tx_err_event,
  output logic rx_overrun_flag,
  output logic irq_request
);
  state_type s_q;
  state_type s_d;

  src_type set_v;
  src_type clr_v;
  src_type wen_v;
  logic wr_v;
  logic lost_word_v;

  // enables come from the low nibble of a write
  function automatic src_type enable_field(
    input logic [15:0] word
  );
    src_type f;
    f.tx_err = word[tx_err_irq_en_bit];
    f.tx = word[tx_irq_en_bit];
    f.rx_err = word[rx_err_irq_en_bit];
    f.rx = word[rx_irq_en_bit];
    return f;
  endfunction

  // a 0 in any clear bit is simply ignored
  function automatic src_type clear_field(
    input logic [15:0] word
  );
    src_type f;
    f.tx_err = word[tx_err_clear_bit]; // [R9]
    f.tx = word[tx_clear_bit]; // [R7] [R8]
    f.rx_err = word[rx_err_clear_bit]; // [R6]
    f.rx = word[rx_clear_bit]; // [R5]
    return f;
  endfunction

  // clears only act in the cycle of the write itself
  function automatic src_type write_clears(
    input logic wr,
    input logic [15:0] word
  );
    src_type f;
    f = '0;
    if (wr) begin
      f = clear_field(word); // [R13]
    end
    return f;
  endfunction

  // one set request per source from the event inputs
  function automatic src_type event_field(
    input logic tx_err,
    input logic tx,
    input logic rx_err,
    input logic rx
  );
    src_type f;
    f.tx_err = tx_err;
    f.tx = tx;
    f.rx_err = rx_err;
    f.rx = rx;
    return f;
  endfunction

  // set wins over a same-cycle clear, so no event is lost
  function automatic logic hold_or_set(
    input logic held,
    input logic clr,
    input logic set
  );
    return (held & ~clr) | set;
  endfunction

  function automatic src_type next_pending(
    input src_type held,
    input src_type clr,
    input src_type set
  );
    src_type f;
    f.tx_err = hold_or_set(
      held.tx_err,
      clr.tx_err,
      set.tx_err
    ); // [R1]
    f.tx = hold_or_set(
      held.tx,
      clr.tx,
      set.tx
    ); // [R7]
    f.rx_err = hold_or_set(
      held.rx_err,
      clr.rx_err,
      set.rx_err
    ); // [R6]
    f.rx = hold_or_set(
      held.rx,
      clr.rx,
      set.rx
    ); // [R5]
    return f;
  endfunction

  // a source asks only while pending and enabled
  function automatic logic source_active(
    input logic pend,
    input logic en
  );
    return pend & en;
  endfunction

  function automatic logic any_request(
    input src_type pend,
    input src_type en
  );
    logic r;
    r = 1'h0;
    r = r | source_active(pend.tx_err, en.tx_err);
    r = r | source_active(pend.tx, en.tx);
    r = r | source_active(pend.rx_err, en.rx_err); // [R4]
    r = r | source_active(pend.rx, en.rx); // [R3]
    return r;
  endfunction

  // clear bits and reserved bits always read zero
  function automatic logic [15:0] read_word(
    input state_type s
  );
    logic [15:0] w;
    w = status_ctrl_reset;

    w[rx_irq_en_bit] = s.enable.rx;
    w[rx_err_irq_en_bit] = s.enable.rx_err;
    w[tx_irq_en_bit] = s.enable.tx;
    w[tx_err_irq_en_bit] = s.enable.tx_err;

    w[rx_pending_bit] = s.pending.rx;
    w[rx_err_pending_bit] = s.pending.rx_err;
    w[tx_pending_bit] = s.pending.tx;
    w[tx_err_pending_bit] = s.pending.tx_err;

    w[rx_clear_bit] = 1'h0; // [R13]
    w[rx_err_clear_bit] = 1'h0;
    w[tx_clear_bit] = 1'h0;
    w[tx_err_clear_bit] = 1'h0;

    w[15:12] = 4'h0;
    return w;
  endfunction

  always_comb begin
    wr_v = reg_wr;

    // a word lost into a full fifo is the receive error condition
    lost_word_v = rx_word_done & rx_fifo_full; // [R11]

    set_v = event_field(
      tx_err_event,
      tx_event,
      lost_word_v,
      rx_event
    ); // [R1]

    clr_v = write_clears(wr_v, reg_wdata); // [R5] [R6] [R7] [R8] [R9]

    wen_v = s_q.enable;
    if (wr_v) begin
      wen_v = enable_field(reg_wdata); // [R3] [R4]
    end

    s_d = s_q;
    s_d.enable = wen_v;

    // pending bits have no write path of their own
    s_d.pending = next_pending(s_q.pending, clr_v, set_v); // [R2] [R13]

    // request is registered from next state so it moves with the flags
    s_d.irq = any_request(s_d.pending, s_d.enable); // [R12]

    s_d.overrun = lost_word_v; // [R11]
  end

  // async reset clears every field, request included
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0; // [R10]
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = read_word(s_q); // [R13] [R2]

  // one-cycle pulse, the pending bit keeps the lasting record
  assign rx_overrun_flag = s_q.overrun;

  assign irq_request = s_q.irq;
endmodule
`default_nettype wire
